// ===== rtl/asp_pkg.sv
// Constants, encodings and state layout of the asynchronous serial port.
// Assumes one 250 MHz clock that also serves as the serial reference clock.
package asp_pkg;
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_DIVH = 8'h04;
   localparam logic [7:0] OFF_IIR  = 8'h08;
   localparam logic [7:0] OFF_LCR  = 8'h0c;
   localparam logic [7:0] OFF_MCR  = 8'h10;
   localparam logic [7:0] OFF_LSR  = 8'h14;
   localparam logic [7:0] OFF_MSR  = 8'h18;
   localparam logic [7:0] OFF_USR  = 8'h7c;
   localparam int LCR_DIVISOR_ACCESS_BIT = 7;
   localparam int LCR_BRK  = 6;
   localparam int LCR_EPS  = 4;
   localparam int LCR_PEN  = 3;
   localparam int LCR_STOP = 2;
   localparam int MCR_INFRARED_MODE_ENABLE = 6;
   localparam int MCR_AFCE = 5;
   localparam int MCR_RTS  = 1;
   localparam int IER_RDA  = 0;
   localparam int IER_THR  = 1;
   localparam int IER_LS   = 2;
   localparam int IER_MS   = 3;
   localparam logic [3:0] IID_MS   = 4'h0;
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_THR  = 4'h2;
   localparam logic [3:0] IID_RDA  = 4'h4;
   localparam logic [3:0] IID_LS   = 4'h6;
   localparam logic [3:0] IID_BUSY = 4'h7;
   localparam logic [3:0] IID_CTO  = 4'hc;
   localparam logic [1:0] FIFO_ON  = 2'h3;
   localparam logic [1:0] FIFO_OFF = 2'h0;
   localparam logic [3:0] FIFO_FULL   = 4'h8;
   localparam logic [3:0] DEPTH_ONE   = 4'h1;
   localparam logic [3:0] RT_ONE      = 4'h1;
   localparam logic [3:0] RT_QUARTER  = 4'h2;
   localparam logic [3:0] RT_HALF     = 4'h4;
   localparam logic [3:0] RT_NEAR     = 4'h6;
   localparam logic [3:0] TET_EMPTY   = 4'h0;
   localparam logic [3:0] TET_TWO     = 4'h2;
   localparam logic [3:0] TET_QUARTER = 4'h2;
   localparam logic [3:0] TET_HALF    = 4'h4;
   localparam logic [5:0] BIT_END    = 6'h0f;
   localparam logic [5:0] MID_TICK   = 6'h07;
   localparam logic [5:0] STOP15_END = 6'h17;
   localparam logic [5:0] STOP2_END  = 6'h1f;
   localparam logic [5:0] IR_PULSE   = 6'h03;
   localparam int TOUT_CHARS     = 4;
   localparam int TOUT_CHAR_BITS = 10;
   localparam logic [9:0] TOUT_TICKS = 10'(TOUT_CHARS * TOUT_CHAR_BITS * 16);
   localparam logic [7:0] REG_RST = 8'h00;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_PAR   = 5'h08,
      TX_STOP  = 5'h10
   } asp_txst_t;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_PAR   = 5'h08,
      RX_STOP  = 5'h10
   } asp_rxst_t;

   typedef struct packed {
      logic [7:0]      dll;
      logic [7:0]      divisor_high_byte;
      logic [3:0]      interrupt_enable;
      logic [7:0]      line_control;
      logic [6:0]      modem_control;
      logic            fen;
      logic [1:0]      rt;
      logic [1:0]      tx_empty_threshold;
      logic            dma_signal_mode;
      logic [15:0]     baud_cnt;
      logic [2:0]      rsy;
      logic [2:0]      csy;
      logic            rxf;
      logic            rxp;
      logic            ctsf;
      asp_txst_t       tst;
      logic [5:0]      tsub;
      logic [2:0]      tbit;
      logic [7:0]      tsh;
      logic            tpar;
      logic [7:0][7:0] txm;
      logic [2:0]      twp;
      logic [2:0]      trp;
      logic [3:0]      tcnt;
      asp_rxst_t       rst_s;
      logic [5:0]      rsub;
      logic [2:0]      rbit;
      logic [7:0]      rsh;
      logic            rperr;
      logic [7:0][7:0] rxm;
      logic [2:0]      rwp;
      logic [2:0]      rrp;
      logic [3:0]      rcnt;
      logic            oe;
      logic            pe;
      logic            fe;
      logic            bi;
      logic            dcts;
      logic            thre_ack;
      logic            bdet;
      logic [9:0]      tout;
      logic            line;
      logic            ir;
      logic            rts_n;
      logic            irq;
      logic            dma_tx;
      logic            dma_rx;
      logic [31:0]     rdata;
   } asp_state_t;
endpackage

// ===== rtl/asp_top.sv
// Asynchronous serial port: register bank, baud generator, transmitter, receiver, FIFOs.
// Assumes a simple strobe register port on clk and serial pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module asp_top #(
   parameter bit LEGACY_16550 = 1'b0,
   parameter bit HAS_IR       = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output var  logic [31:0] rd_data,
   input  wire logic        serial_in,
   input  wire logic        cts_n,
   output var  logic        serial_out,
   output var  logic        rts_n,
   output var  logic        ir_out,
   output var  logic        irq,
   output var  logic        dma_tx_req,
   output var  logic        dma_rx_req
);
   asp_pkg::asp_state_t s_r;
   asp_pkg::asp_state_t s_nxt;
   logic [15:0] div;
   logic        busy;
   logic        dacc;
   logic [2:0]  nb_end;
   logic [3:0]  cap;
   logic [3:0]  trig;
   logic [3:0]  tlvl;
   logic        tick;
   logic [5:0]  stop_end;
   logic        thre_cond;
   logic        tout_hit;
   logic [3:0]  pending_interrupt_code;
   logic        rx_push;
   logic        rx_pop;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_clr;
   logic        tx_clr;
   logic [7:0]  tx_char;
   logic [31:0] rval;

   function automatic logic [7:0] char_mask(input logic [1:0] data_length_select);
      case (data_length_select)
         2'h0:    char_mask = 8'h1f;
         2'h1:    char_mask = 8'h3f;
         2'h2:    char_mask = 8'h7f;
         default: char_mask = 8'hff;
      endcase
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic even);
      par_bit = ^d ^ ~even;
   endfunction

   function automatic logic [3:0] rx_trig(input logic [1:0] rt);
      case (rt)
         2'h0:    rx_trig = asp_pkg::RT_ONE;
         2'h1:    rx_trig = asp_pkg::RT_QUARTER;
         2'h2:    rx_trig = asp_pkg::RT_HALF;
         default: rx_trig = asp_pkg::RT_NEAR;
      endcase
   endfunction

   function automatic logic [3:0] tx_level(input logic [1:0] tx_empty_threshold);
      case (tx_empty_threshold)
         2'h0:    tx_level = asp_pkg::TET_EMPTY;
         2'h1:    tx_level = asp_pkg::TET_TWO;
         2'h2:    tx_level = asp_pkg::TET_QUARTER;
         default: tx_level = asp_pkg::TET_HALF;
      endcase
   endfunction

   function automatic logic [5:0] inc6(input logic [5:0] v);
      inc6 = v + 6'h01;
   endfunction

   always_comb begin
      s_nxt   = s_r;
      div     = {s_r.divisor_high_byte, s_r.dll};
      busy    = (s_r.tst != asp_pkg::TX_IDLE) || (s_r.rst_s != asp_pkg::RX_IDLE)
                || (s_r.tcnt != 4'h0) || (s_r.rcnt != 4'h0);
      dacc    = s_r.line_control[asp_pkg::LCR_DIVISOR_ACCESS_BIT] && (LEGACY_16550 || !busy);
      nb_end  = 3'h4 + {1'b0, s_r.line_control[1:0]};
      cap     = s_r.fen ? asp_pkg::FIFO_FULL : asp_pkg::DEPTH_ONE;
      trig    = rx_trig(s_r.rt);
      tlvl    = tx_level(s_r.tx_empty_threshold);
      tick    = (div != 16'h0) && (s_r.baud_cnt >= div - 16'h0001);
      stop_end = !s_r.line_control[asp_pkg::LCR_STOP] ? asp_pkg::BIT_END :
                 (s_r.line_control[1:0] == 2'h0) ? asp_pkg::STOP15_END : asp_pkg::STOP2_END;
      thre_cond = s_r.fen ? (s_r.tcnt <= tlvl) : (s_r.tcnt == 4'h0);
      tout_hit  = s_r.fen && (s_r.tout == asp_pkg::TOUT_TICKS);
      rx_push = 1'b0;
      rx_pop  = 1'b0;
      tx_push = 1'b0;
      tx_pop  = 1'b0;
      rx_clr  = 1'b0;
      tx_clr  = 1'b0;
      tx_char = s_r.txm[s_r.trp] & char_mask(s_r.line_control[1:0]);
      rval    = 32'h0;

      // Priority encoder for the pending source
      if (s_r.interrupt_enable[asp_pkg::IER_LS] && (s_r.oe || s_r.pe || s_r.fe || s_r.bi)) begin
         pending_interrupt_code = asp_pkg::IID_LS;
      end else if (s_r.interrupt_enable[asp_pkg::IER_RDA]
                   && (s_r.fen ? (s_r.rcnt >= trig) : (s_r.rcnt != 4'h0))) begin
         pending_interrupt_code = asp_pkg::IID_RDA;
      end else if (s_r.interrupt_enable[asp_pkg::IER_RDA] && tout_hit) begin
         pending_interrupt_code = asp_pkg::IID_CTO;
      end else if (s_r.interrupt_enable[asp_pkg::IER_THR] && thre_cond && !s_r.thre_ack) begin
         pending_interrupt_code = asp_pkg::IID_THR;
      end else if (s_r.interrupt_enable[asp_pkg::IER_MS] && s_r.dcts) begin
         pending_interrupt_code = asp_pkg::IID_MS;
      end else if (s_r.bdet) begin
         pending_interrupt_code = asp_pkg::IID_BUSY;
      end else begin
         pending_interrupt_code = asp_pkg::IID_NONE;
      end

      s_nxt.baud_cnt = (tick || div == 16'h0) ? 16'h0 : s_r.baud_cnt + 16'h0001;

      // Pin synchronisers; a level is taken once the last two stages agree
      s_nxt.rsy = {s_r.rsy[1:0], serial_in};
      s_nxt.csy = {s_r.csy[1:0], cts_n};
      if (s_r.rsy[1] == s_r.rsy[2]) begin
         s_nxt.rxf = s_r.rsy[2];
      end
      if (s_r.csy[1] == s_r.csy[2]) begin
         s_nxt.ctsf = s_r.csy[2];
      end
      s_nxt.rxp = s_r.rxf;

      // Sticky flags: clears first so a same-cycle event wins
      if (!s_r.tst[0] || s_r.tcnt != 4'h0 || !thre_cond) begin
         s_nxt.thre_ack = s_r.thre_ack && thre_cond;
      end

      if (wr_en) begin
         case (addr)
            asp_pkg::OFF_DATA: begin
               if (dacc) begin
                  s_nxt.dll = wdata[7:0];
               end else if (!s_r.line_control[asp_pkg::LCR_DIVISOR_ACCESS_BIT] && s_r.tcnt < cap) begin
                  tx_push = 1'b1;
                  s_nxt.thre_ack = 1'b0;
               end
            end
            asp_pkg::OFF_DIVH: begin
               if (dacc) begin
                  s_nxt.divisor_high_byte = wdata[7:0];
               end else if (!s_r.line_control[asp_pkg::LCR_DIVISOR_ACCESS_BIT]) begin
                  s_nxt.interrupt_enable = wdata[3:0];
               end
            end
            asp_pkg::OFF_IIR: begin
               s_nxt.fen  = wdata[0];
               s_nxt.rt   = wdata[7:6];
               s_nxt.tx_empty_threshold  = wdata[5:4];
               s_nxt.dma_signal_mode = wdata[3];
               rx_clr = wdata[1] || (wdata[0] != s_r.fen);
               tx_clr = wdata[2] || (wdata[0] != s_r.fen);
            end
            asp_pkg::OFF_LCR: begin
               s_nxt.line_control[asp_pkg::LCR_BRK] = wdata[asp_pkg::LCR_BRK];
               if (LEGACY_16550 || !busy) begin
                  s_nxt.line_control = {wdata[7:6], 1'b0, wdata[4:0]};
               end else begin
                  s_nxt.bdet = 1'b1;
               end
            end
            asp_pkg::OFF_MCR: begin
               s_nxt.modem_control = {wdata[6] && HAS_IR, wdata[5:0]};
            end
            default: begin
            end
         endcase
      end

      if (rd_en) begin
         case (addr)
            asp_pkg::OFF_DATA: begin
               if (dacc) begin
                  rval = {24'h0, s_r.dll};
               end else if (!s_r.line_control[asp_pkg::LCR_DIVISOR_ACCESS_BIT]) begin
                  rval = {24'h0, s_r.rxm[s_r.rrp]};
                  rx_pop = (s_r.rcnt != 4'h0);
               end
            end
            asp_pkg::OFF_DIVH: begin
               if (dacc) begin
                  rval = {24'h0, s_r.divisor_high_byte};
               end else if (!s_r.line_control[asp_pkg::LCR_DIVISOR_ACCESS_BIT]) begin
                  rval = {28'h0, s_r.interrupt_enable};
               end
            end
            asp_pkg::OFF_IIR: begin
               rval = {24'h0, (s_r.fen ? asp_pkg::FIFO_ON : asp_pkg::FIFO_OFF), 2'h0, pending_interrupt_code};
               if (pending_interrupt_code == asp_pkg::IID_THR) begin
                  s_nxt.thre_ack = 1'b1;
               end
            end
            asp_pkg::OFF_LCR: rval = {24'h0, s_r.line_control};
            asp_pkg::OFF_MCR: rval = {25'h0, s_r.modem_control};
            asp_pkg::OFF_LSR: begin
               rval = {24'h0, s_r.fen && (s_r.pe || s_r.fe || s_r.bi),
                       (s_r.tcnt == 4'h0) && (s_r.tst == asp_pkg::TX_IDLE),
                       s_r.tcnt == 4'h0, s_r.bi, s_r.fe, s_r.pe, s_r.oe,
                       s_r.rcnt != 4'h0};
               s_nxt.oe = 1'b0;
               s_nxt.pe = 1'b0;
               s_nxt.fe = 1'b0;
               s_nxt.bi = 1'b0;
            end
            asp_pkg::OFF_MSR: begin
               rval = {27'h0, !s_r.ctsf, 3'h0, s_r.dcts};
               s_nxt.dcts = 1'b0;
            end
            asp_pkg::OFF_USR: begin
               rval = {27'h0, s_r.rcnt == cap, s_r.rcnt != 4'h0, s_r.tcnt == 4'h0,
                       s_r.tcnt != cap, busy};
               s_nxt.bdet = 1'b0;
            end
            default: rval = 32'h0;
         endcase
      end
      s_nxt.rdata = rval;

      if (s_r.ctsf != s_nxt.ctsf) begin
         s_nxt.dcts = 1'b1;
      end

      // Transmitter
      case (s_r.tst)
         asp_pkg::TX_IDLE: begin
            if (s_r.tcnt != 4'h0 && !(s_r.modem_control[asp_pkg::MCR_AFCE] && s_r.ctsf)) begin
               tx_pop = 1'b1;
               s_nxt.tsh = tx_char;
               s_nxt.tpar = par_bit(tx_char, s_r.line_control[asp_pkg::LCR_EPS]);
               s_nxt.tsub = 6'h0;
               s_nxt.tst = asp_pkg::TX_START;
            end
         end
         asp_pkg::TX_START: begin
            if (tick) begin
               s_nxt.tsub = inc6(s_r.tsub);
               if (s_r.tsub == asp_pkg::BIT_END) begin
                  s_nxt.tsub = 6'h0;
                  s_nxt.tbit = 3'h0;
                  s_nxt.tst = asp_pkg::TX_DATA;
               end
            end
         end
         asp_pkg::TX_DATA: begin
            if (tick) begin
               s_nxt.tsub = inc6(s_r.tsub);
               if (s_r.tsub == asp_pkg::BIT_END) begin
                  s_nxt.tsub = 6'h0;
                  s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
                  s_nxt.tbit = s_r.tbit + 3'h1;
                  if (s_r.tbit == nb_end) begin
                     s_nxt.tst = s_r.line_control[asp_pkg::LCR_PEN] ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
                  end
               end
            end
         end
         asp_pkg::TX_PAR: begin
            if (tick) begin
               s_nxt.tsub = inc6(s_r.tsub);
               if (s_r.tsub == asp_pkg::BIT_END) begin
                  s_nxt.tsub = 6'h0;
                  s_nxt.tst = asp_pkg::TX_STOP;
               end
            end
         end
         asp_pkg::TX_STOP: begin
            if (tick) begin
               s_nxt.tsub = inc6(s_r.tsub);
               if (s_r.tsub == stop_end) begin
                  s_nxt.tst = asp_pkg::TX_IDLE;
               end
            end
         end
         default: s_nxt.tst = asp_pkg::TX_IDLE;
      endcase

      // Receiver
      case (s_r.rst_s)
         asp_pkg::RX_IDLE: begin
            if (s_r.rxp && !s_r.rxf) begin
               s_nxt.rsub = 6'h0;
               s_nxt.rst_s = asp_pkg::RX_START;
            end
         end
         asp_pkg::RX_START: begin
            if (tick) begin
               s_nxt.rsub = inc6(s_r.rsub);
               if (s_r.rsub == asp_pkg::MID_TICK) begin
                  s_nxt.rsub = 6'h0;
                  s_nxt.rbit = 3'h0;
                  s_nxt.rsh = 8'h0;
                  s_nxt.rperr = 1'b0;
                  s_nxt.rst_s = s_r.rxf ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
               end
            end
         end
         asp_pkg::RX_DATA: begin
            if (tick) begin
               s_nxt.rsub = inc6(s_r.rsub);
               if (s_r.rsub == asp_pkg::BIT_END) begin
                  s_nxt.rsub = 6'h0;
                  s_nxt.rsh[s_r.rbit] = s_r.rxf;
                  s_nxt.rbit = s_r.rbit + 3'h1;
                  if (s_r.rbit == nb_end) begin
                     s_nxt.rst_s = s_r.line_control[asp_pkg::LCR_PEN] ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
                  end
               end
            end
         end
         asp_pkg::RX_PAR: begin
            if (tick) begin
               s_nxt.rsub = inc6(s_r.rsub);
               if (s_r.rsub == asp_pkg::BIT_END) begin
                  s_nxt.rsub = 6'h0;
                  s_nxt.rperr = s_r.rxf != par_bit(s_r.rsh, s_r.line_control[asp_pkg::LCR_EPS]);
                  s_nxt.rst_s = asp_pkg::RX_STOP;
               end
            end
         end
         asp_pkg::RX_STOP: begin
            if (tick) begin
               s_nxt.rsub = inc6(s_r.rsub);
               if (s_r.rsub == asp_pkg::BIT_END) begin
                  rx_push = 1'b1;
                  s_nxt.pe = s_r.rperr || s_nxt.pe;
                  s_nxt.fe = !s_r.rxf || s_nxt.fe;
                  s_nxt.bi = (!s_r.rxf && s_r.rsh == 8'h0) || s_nxt.bi;
                  s_nxt.rst_s = asp_pkg::RX_IDLE;
               end
            end
         end
         default: s_nxt.rst_s = asp_pkg::RX_IDLE;
      endcase

      // Character timeout counter in 16x ticks
      if (s_r.rcnt == 4'h0 || rx_pop || s_r.rst_s != asp_pkg::RX_IDLE) begin
         s_nxt.tout = 10'h0;
      end else if (tick && !tout_hit) begin
         s_nxt.tout = s_r.tout + 10'h001;
      end

      // FIFO pointer update; a full receiver drops or overwrites and flags overrun
      if (tx_clr) begin
         s_nxt.twp = 3'h0;
         s_nxt.trp = 3'h0;
         s_nxt.tcnt = 4'h0;
      end else begin
         if (tx_push) begin
            s_nxt.txm[s_r.twp] = wdata[7:0];
            s_nxt.twp = s_r.fen ? s_r.twp + 3'h1 : s_r.twp;
         end
         if (tx_pop) begin
            s_nxt.trp = s_r.fen ? s_r.trp + 3'h1 : s_r.trp;
         end
         s_nxt.tcnt = s_r.tcnt + {3'h0, tx_push} - {3'h0, tx_pop};
      end
      if (rx_clr) begin
         s_nxt.rwp = 3'h0;
         s_nxt.rrp = 3'h0;
         s_nxt.rcnt = 4'h0;
      end else begin
         if (rx_push && s_r.rcnt == cap) begin
            s_nxt.oe = 1'b1;
            if (!s_r.fen) begin
               s_nxt.rxm[s_r.rrp] = s_r.rsh & char_mask(s_r.line_control[1:0]);
            end
            rx_push = 1'b0;
         end
         if (rx_push) begin
            s_nxt.rxm[s_r.rwp] = s_r.rsh & char_mask(s_r.line_control[1:0]);
            s_nxt.rwp = s_r.fen ? s_r.rwp + 3'h1 : s_r.rwp;
         end
         if (rx_pop) begin
            s_nxt.rrp = s_r.fen ? s_r.rrp + 3'h1 : s_r.rrp;
         end
         s_nxt.rcnt = s_r.rcnt + {3'h0, rx_push} - {3'h0, rx_pop};
      end

      // Registered pin drivers
      case (s_nxt.tst)
         asp_pkg::TX_START: s_nxt.line = 1'b0;
         asp_pkg::TX_DATA:  s_nxt.line = s_nxt.tsh[0];
         asp_pkg::TX_PAR:   s_nxt.line = s_nxt.tpar;
         default:           s_nxt.line = 1'b1;
      endcase
      s_nxt.ir = s_nxt.modem_control[asp_pkg::MCR_INFRARED_MODE_ENABLE] && !s_nxt.line && (s_nxt.tsub < asp_pkg::IR_PULSE);
      if (s_nxt.line_control[asp_pkg::LCR_BRK]) begin
         s_nxt.line = 1'b0;
         s_nxt.ir = 1'b0;
      end
      s_nxt.rts_n = !(s_r.modem_control[asp_pkg::MCR_RTS]
                      && !(s_r.modem_control[asp_pkg::MCR_AFCE] && s_r.fen && s_r.rcnt >= trig));
      s_nxt.irq = (pending_interrupt_code != asp_pkg::IID_NONE);
      s_nxt.dma_rx = s_r.dma_signal_mode ? ((s_r.rcnt >= trig) || tout_hit) : (s_r.rcnt != 4'h0);
      s_nxt.dma_tx = s_r.dma_signal_mode ? thre_cond : (s_r.tcnt == 4'h0);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r       <= '0;
         s_r.line_control   <= asp_pkg::REG_RST;
         s_r.rsy   <= 3'h7;
         s_r.csy   <= 3'h7;
         s_r.rxf   <= 1'b1;
         s_r.rxp   <= 1'b1;
         s_r.ctsf  <= 1'b1;
         s_r.tst   <= asp_pkg::TX_IDLE;
         s_r.rst_s <= asp_pkg::RX_IDLE;
         s_r.line  <= 1'b1;
         s_r.rts_n <= 1'b1;
         s_r.dma_tx <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data    = s_r.rdata;
   assign serial_out = s_r.line;
   assign rts_n      = s_r.rts_n;
   assign ir_out     = s_r.ir;
   assign irq        = s_r.irq;
   assign dma_tx_req = s_r.dma_tx;
   assign dma_rx_req = s_r.dma_rx;
endmodule
`default_nettype wire

// ===== sim/asp_top_assertions.sv
// Checker for the serial port: read format, interrupt gating, break and IR output.
// Assumes line control is written only while the port is idle.
`timescale 1ns/1ps
`default_nettype none
module asp_top_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rd_data,
   input wire logic        serial_in,
   input wire logic        cts_n,
   input wire logic        serial_out,
   input wire logic        rts_n,
   input wire logic        ir_out,
   input wire logic        irq,
   input wire logic        dma_tx_req,
   input wire logic        dma_rx_req
);
   logic       brk_r;
   logic       ir_r;
   logic       divisor_access_bit_r;
   logic [1:0] ier_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow copies of control bits, taken from bus writes
   always_ff @(posedge clk) begin
      if (rst) begin
         brk_r <= 1'b0;
         ir_r <= 1'b0;
         divisor_access_bit_r <= 1'b0;
         ier_r <= 2'h0;
      end else if (wr_en) begin
         if (addr == 8'h0c) begin
            brk_r <= wdata[6];
            divisor_access_bit_r <= wdata[7];
         end
         if (addr == 8'h10) ir_r <= wdata[6];
         if (addr == 8'h04 && !divisor_access_bit_r) ier_r <= wdata[1:0];
      end
   end
   property p_rd_quiet; !$past(rd_en) |-> rd_data == 32'h0; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read cycle");
   property p_id_fmt; rd_en && addr == 8'h08 |=> rd_data[31:4] inside {28'h0, 28'hc}; endproperty
   a_id_fmt: assert property (p_id_fmt) else $error("identity upper bits wrong");
   property p_id_code; rd_en && addr == 8'h08 |=> rd_data[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'hc};
   endproperty
   a_id_code: assert property (p_id_code) else $error("identity code illegal");
   property p_rda_gate; rd_en && addr == 8'h08 && !ier_r[0] |=> !(rd_data[3:0] inside {4'h4, 4'hc}); endproperty
   a_rda_gate: assert property (p_rda_gate) else $error("receive interrupt not gated");
   property p_thr_gate; rd_en && addr == 8'h08 && !ier_r[1] |=> rd_data[3:0] != 4'h2; endproperty
   a_thr_gate: assert property (p_thr_gate) else $error("transmit interrupt not gated");
   property p_brk; brk_r && $past(brk_r) && $past(brk_r, 2) |-> !serial_out; endproperty
   a_brk: assert property (p_brk) else $error("break not driven");
   property p_ir_off; !ir_r && !$past(ir_r) |-> !ir_out; endproperty
   a_ir_off: assert property (p_ir_off) else $error("IR pulse while IR mode off");
   property p_unmapped; rd_en && addr == 8'h20 |=> rd_data == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_brk: cover property (brk_r ##1 !serial_out);
   c_rda: cover property (rd_en && addr == 8'h08 ##1 rd_data[3:0] == 4'h4);
   c_irq: cover property ($rose(irq));
endmodule
bind asp_top asp_top_checker u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .serial_in(serial_in), .cts_n(cts_n), .serial_out(serial_out), .rts_n(rts_n),
   .ir_out(ir_out), .irq(irq), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
`default_nettype wire

// ===== sim/asp_remote.sv
// Remote serial device: sends 8-bit even-parity frames, captures frames from the port.
// Assumes a bit time of BIT clocks matching the programmed divisor.
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
   parameter int BIT = 32
) (
   input  wire logic       clk,
   input  wire logic       line_in,
   input  wire logic       go,
   input  wire logic [7:0] tx_byte,
   output var  logic       line_out,
   output var  logic       cts_n,
   output var  logic [8:0] got,
   output var  logic [3:0] got_n
);
   initial begin
      line_out = 1'b1;
      cts_n = 1'b0;
      got = 9'h0;
      got_n = 4'h0;
   end
   always @(posedge clk) begin
      if (go) begin
         line_out <= 1'b0;
         for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge clk);
            line_out <= (i == 8) ? ^tx_byte : (i == 9) ? 1'b1 : tx_byte[i];
         end
      end
   end
   // Samples data and parity at mid-bit
   always @(negedge line_in) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge clk);
         got[i] <= line_in;
      end
      got_n <= got_n + 4'h1;
   end
endmodule
`default_nettype wire

// ===== sim/asp_top_bench.sv
// Self-checking bench: registers, transmit, receive, FIFO flag, break.
// Assumes divisor 2, so one bit lasts 32 clocks.
`timescale 1ns/1ps
`default_nettype none
module asp_top_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  tx_byte = 8'h00;
   logic [31:0] rd_data, v;
   logic        s_in, cts_n, s_out, irq;
   logic        rts_n, ir_out, dma_tx, dma_rx;
   logic        ir_seen = 1'b0;
   logic [8:0]  got;
   logic [3:0]  got_n, n0;
   int          bad_count = 0, n_compared = 0, cyc = 0;
   asp_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .serial_in(s_in), .cts_n(cts_n), .serial_out(s_out), .rts_n(rts_n), .ir_out(ir_out), .irq(irq),
      .dma_tx_req(dma_tx), .dma_rx_req(dma_rx));
   asp_remote #(.BIT(32)) rem (.clk(clk), .line_in(s_out), .go(go), .tx_byte(tx_byte), .line_out(s_in),
      .cts_n(cts_n), .got(got), .got_n(got_n));
   always #2 clk = ~clk;
   // Remembers any IR pulse seen while a frame goes out
   always @(posedge clk) begin
      if (ir_out) ir_seen <= 1'b1;
   end
   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 q = rd_data;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      rd(a, q);
      chk(q, e);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rc(8'h08, 32'h01);
      rc(8'h0c, 32'h00);
      rc(8'h10, 32'h00);
      rc(8'h04, 32'h00);
      wr(8'h0c, 32'h83);
      wr(8'h00, 32'h02);
      wr(8'h04, 32'h00);
      rc(8'h00, 32'h02);
      wr(8'h0c, 32'h1b);
      rc(8'h0c, 32'h1b);
      wr(8'h04, 32'h01);
      rc(8'h04, 32'h01);
      wr(8'h10, 32'h42);
      n0 = got_n;
      wr(8'h00, 32'ha5);
      for (int k = 0; k < 800 && got_n == n0; k++) @(posedge clk);
      chk({23'h0, got}, {23'h0, ^8'ha5, 8'ha5});
      chk({30'h0, rts_n, ir_seen}, 32'h1);
      tx_byte <= 8'h3c;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      v = 32'h0;
      for (int k = 0; k < 300 && !v[0]; k++) rd(8'h14, v);
      chk(v & 32'h1f, 32'h01);
      chk({29'h0, irq, dma_rx, dma_tx}, 32'h7);
      rc(8'h08, 32'h04);
      rc(8'h00, 32'h3c);
      rd(8'h14, v);
      chk({30'h0, v[0], dma_rx}, 32'h0);
      wr(8'h08, 32'h01);
      rc(8'h08, 32'hc1);
      wr(8'h08, 32'h00);
      rc(8'h08, 32'h01);
      wr(8'h10, 32'h40);
      rc(8'h10, 32'h40);
      chk({31'h0, rts_n}, 32'h1);
      wr(8'h20, 32'hff);
      rc(8'h20, 32'h00);
      wr(8'h0c, 32'h5b);
      repeat (3) @(posedge clk);
      chk({31'h0, s_out}, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
